// [slpag_pkg.sv]
package slpag_pkg;
	// apb register byte offsets
	localparam logic [11:0] SLPAG_OFF_STACK_PTR = 12'h000;
	localparam logic [11:0] SLPAG_OFF_STACK_LIMIT = 12'h004;
	localparam logic [11:0] SLPAG_OFF_TABLE_PAGE = 12'h008;
	localparam logic [11:0] SLPAG_OFF_VIS_PAGE = 12'h00C;
	localparam logic [11:0] SLPAG_OFF_CORE_CTRL = 12'h010;
	localparam logic [11:0] SLPAG_OFF_STATUS = 12'h014;
	// field positions
	localparam int SLPAG_CORE_VIS_BIT = 2;
	localparam int SLPAG_TABLE_PAGE_REGISTER_CFG_BIT = 7;
	localparam int SLPAG_EA_MSB = 15;
	// reset values
	localparam logic [15:0] SLPAG_SP_RESET = 16'h0800;
	localparam logic [7:0] SLPAG_PAGE_RESET = 8'h00;
	localparam logic [15:0] SLPAG_CORE_RESET = 16'h0000;
	// fixed lower stack bound, the two meaningful visibility pages and the stack word step
	localparam logic [15:0] SLPAG_STACK_FLOOR = 16'h0800;
	localparam logic [7:0] SLPAG_VIS_PROGRAM = 8'h00;
	localparam logic [7:0] SLPAG_VIS_EEPROM = 8'hFF;
	localparam logic [15:0] SLPAG_WORD_STEP = 16'h0002;
	// stack operation codes from the datapath
	typedef enum logic [2:0] {
		SLPAG_OP_NONE = 3'h0,
		SLPAG_OP_PUSH = 3'h1,
		SLPAG_OP_POP = 3'h3,
		SLPAG_OP_CALL = 3'h2,
		SLPAG_OP_EXC = 3'h6,
		SLPAG_OP_REF = 3'h7
	} slpag_op_t;
endpackage

// [slpag_limit_reg.sv]
`timescale 1ns/100ps
module slpag_limit_reg
	import slpag_pkg::*;
(
	// clock
	input wire logic pclk,
	// write side
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// stored limit, bit zero forced clear
	output logic [15:0] limit_q
);
	logic [15:0] limit_d;

	// word aligned: bit zero never stored
	always_comb begin
		limit_d = limit_q;
		if (wr_en) begin
			limit_d = {wr_data[15:1], 1'b0};
		end
	end

	// no reset on purpose: content is undefined until software writes it
	always_ff @(posedge pclk) begin
		limit_q <= limit_d;
	end
endmodule // slpag_limit_reg

// [slpag_core.sv]
// Summary of operation
// - stack pointer holds first free word; stack grows upward.
// - pop predecrements before reading; push writes then postincrements.
// - call push zero-extends counter high byte.
// - exception push places status low byte above counter high byte.
// - stack limit bit zero always reads zero.
// - stack limit is not reset; undefined until written.
// - every push, call and exception address is compared with the limit.
// - push at limit is fine; push beyond limit traps.
// - stack address below 0800h raises underflow trap.
// - table address is table page above 16-bit effective address.
// - table page bit 7 selects user or configuration space.
// - remap joins visibility page with 15 low address bits.
// - remap address bit 23 forced zero, user memory only.
// - remap ignores address bit 15; uses visibility page bit 0.
// - visibility page only meaningful as 00 or FF.
// - table access needs no alignment; config reads allowed.
// - table sees all bytes; remap reads only the low word.
// - configuration space allows table reads only, writes blocked.
// - remap only with visibility enable set and address MSb one.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module slpag_core
	import slpag_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// stack requests from the datapath
	input wire logic [2:0] stack_op,
	input wire logic [23:0] pc_value,
	input wire logic [7:0] status_low_byte,
	output logic [15:0] stack_addr,
	output logic [31:0] stack_push_data,
	output logic stack_trap,
	// program space requests
	input wire logic tbl_req,
	input wire logic tbl_write,
	input wire logic [15:0] tbl_ea,
	input wire logic data_req,
	input wire logic [15:0] data_ea,
	output logic [23:0] prog_addr,
	output logic prog_valid,
	output logic prog_write,
	output logic prog_config,
	output logic prog_low_word_only,
	output logic prog_blocked
);
	logic [15:0] sp_q, sp_d;
	logic [7:0] tbl_page_q, tbl_page_d;
	logic [7:0] vis_page_q, vis_page_d;
	logic [15:0] core_q, core_d;
	logic [15:0] addr_q, addr_d;
	logic [31:0] push_q, push_d;
	logic trap_q, trap_d;
	logic [23:0] pa_q, pa_d;
	logic pv_q, pv_d, pw_q, pw_d, pc_q, pc_d, pl_q, pl_d, pb_q, pb_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic [15:0] limit_q;
	logic limit_wr;
	logic [15:0] gen_ea;
	logic is_push, is_stack;
	logic remap_hit;
	logic vis_bad_q, vis_bad_d;
	slpag_op_t op;

	// decode of an apb address at one offset
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	assign op = slpag_op_t'(stack_op);
	assign pready = 1'b1; // zero wait states
	assign prdata = rdata_q;
	assign pslverr = err_q;
	assign stack_addr = addr_q;
	assign stack_push_data = push_q;
	assign stack_trap = trap_q;
	assign prog_addr = pa_q;
	assign prog_valid = pv_q;
	assign prog_write = pw_q;
	assign prog_config = pc_q;
	assign prog_low_word_only = pl_q;
	assign prog_blocked = pb_q;
	assign limit_wr = psel & penable & pwrite
		& hit(paddr, SLPAG_OFF_STACK_LIMIT);

	// the limit store has no reset, so it sits in its own module
	// unreset limit
	slpag_limit_reg u_limit (
		.pclk(pclk),
		.wr_en(limit_wr),
		.wr_data(pwdata[15:0]),
		.limit_q(limit_q)
	);

	// effective address generated by the stack operation
	always_comb begin
		is_push = (op == SLPAG_OP_PUSH) | (op == SLPAG_OP_CALL)
			| (op == SLPAG_OP_EXC);
		is_stack = is_push | (op == SLPAG_OP_POP) | (op == SLPAG_OP_REF);
		if (op == SLPAG_OP_POP) begin
			gen_ea = sp_q - SLPAG_WORD_STEP;
		end else begin
			gen_ea = sp_q;
		end
	end

	// stack pointer, push data and trap
	always_comb begin
		sp_d = sp_q;
		addr_d = addr_q;
		push_d = push_q;
		trap_d = 1'b0;
		if (psel & penable & pwrite & hit(paddr, SLPAG_OFF_STACK_PTR)) begin
			sp_d = {pwdata[15:1], 1'b0};
		end
		if (is_stack) begin
			addr_d = gen_ea;
			trap_d = (is_push & (gen_ea > limit_q))
				| (gen_ea < SLPAG_STACK_FLOOR);
		end
		if (is_push) begin
			sp_d = sp_q + SLPAG_WORD_STEP;
		end else if (op == SLPAG_OP_POP) begin
			sp_d = gen_ea;
		end
		unique case (op)
			SLPAG_OP_CALL: push_d = {8'h00, pc_value};
			SLPAG_OP_EXC: push_d = {status_low_byte, pc_value};
			SLPAG_OP_PUSH: push_d = {8'h00, pc_value};
			default: push_d = push_q;
		endcase
	end

	// program address formation
	always_comb begin
		pa_d = pa_q;
		pv_d = 1'b0;
		pw_d = 1'b0;
		pc_d = pc_q;
		pl_d = pl_q;
		pb_d = 1'b0;
		remap_hit = data_req & core_q[SLPAG_CORE_VIS_BIT]
			& data_ea[SLPAG_EA_MSB];
		if (tbl_req) begin
			pa_d = {tbl_page_q, tbl_ea};
			pc_d = tbl_page_q[SLPAG_TABLE_PAGE_REGISTER_CFG_BIT];
			pl_d = 1'b0;
			pb_d = tbl_write & tbl_page_q[SLPAG_TABLE_PAGE_REGISTER_CFG_BIT];
			pv_d = ~pb_d;
			pw_d = tbl_write & ~pb_d;
		end else if (remap_hit) begin
			pa_d = {1'b0, vis_page_q, data_ea[14:0]};
			pc_d = 1'b0;
			pl_d = 1'b1;
			pv_d = 1'b1;
		end
	end

	// software registers and read data
	always_comb begin
		tbl_page_d = tbl_page_q;
		vis_page_d = vis_page_q;
		core_d = core_q;
		vis_bad_d = vis_bad_q;
		rdata_d = rdata_q;
		err_d = 1'b0;
		if (psel & penable & pwrite) begin
			if (hit(paddr, SLPAG_OFF_TABLE_PAGE)) begin
				tbl_page_d = pwdata[7:0];
			end
			if (hit(paddr, SLPAG_OFF_VIS_PAGE)) begin
				vis_page_d = pwdata[7:0];
				vis_bad_d = (pwdata[7:0] != SLPAG_VIS_PROGRAM)
					& (pwdata[7:0] != SLPAG_VIS_EEPROM);
			end
			if (hit(paddr, SLPAG_OFF_CORE_CTRL)) begin
				core_d = pwdata[15:0];
			end
		end
		if (psel & ~penable & ~pwrite) begin
			unique case (paddr)
				SLPAG_OFF_STACK_PTR: rdata_d = {16'h0000, sp_q};
				SLPAG_OFF_STACK_LIMIT: rdata_d = {16'h0000,
					limit_q[15:1], 1'b0};
				SLPAG_OFF_TABLE_PAGE: rdata_d = {24'h000000, tbl_page_q};
				SLPAG_OFF_VIS_PAGE: rdata_d = {24'h000000, vis_page_q};
				SLPAG_OFF_CORE_CTRL: rdata_d = {16'h0000, core_q};
				SLPAG_OFF_STATUS: rdata_d = {30'h00000000, vis_bad_q,
					trap_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
		if (psel & ~penable) begin
			err_d = ~(hit(paddr, SLPAG_OFF_STACK_PTR)
				| hit(paddr, SLPAG_OFF_STACK_LIMIT)
				| hit(paddr, SLPAG_OFF_TABLE_PAGE)
				| hit(paddr, SLPAG_OFF_VIS_PAGE)
				| hit(paddr, SLPAG_OFF_CORE_CTRL)
				| hit(paddr, SLPAG_OFF_STATUS));
		end
	end

	// register all state except the limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= SLPAG_SP_RESET;
			tbl_page_q <= SLPAG_PAGE_RESET;
			vis_page_q <= SLPAG_PAGE_RESET;
			core_q <= SLPAG_CORE_RESET;
			vis_bad_q <= 1'b0;
			addr_q <= SLPAG_SP_RESET;
			push_q <= 32'h00000000;
			trap_q <= 1'b0;
			pa_q <= 24'h000000;
			pv_q <= 1'b0;
			pw_q <= 1'b0;
			pc_q <= 1'b0;
			pl_q <= 1'b0;
			pb_q <= 1'b0;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else begin
			sp_q <= sp_d;
			tbl_page_q <= tbl_page_d;
			vis_page_q <= vis_page_d;
			core_q <= core_d;
			vis_bad_q <= vis_bad_d;
			addr_q <= addr_d;
			push_q <= push_d;
			trap_q <= trap_d;
			pa_q <= pa_d;
			pv_q <= pv_d;
			pw_q <= pw_d;
			pc_q <= pc_d;
			pl_q <= pl_d;
			pb_q <= pb_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// checks
	push_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_PUSH) |=> (sp_q == $past(sp_q) + SLPAG_WORD_STEP))
		else $error("push did not advance stack pointer");
	pop_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_POP) |=> (stack_addr == $past(sp_q) - 16'h0002))
		else $error("pop address not predecremented");
	call_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_CALL) |=> (stack_push_data[31:24] == 8'h00))
		else $error("call push top byte not clear");
	exc_status_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_EXC) |=>
		(stack_push_data[31:24] == $past(status_low_byte)))
		else $error("exception push lacks status byte");
	limit_lsb_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && paddr == SLPAG_OFF_STACK_LIMIT)
		|-> (prdata[0] == 1'b0))
		else $error("limit bit zero read as one");
	at_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_PUSH && sp_q == limit_q && sp_q >= 16'h0800)
		|=> !stack_trap)
		else $error("push at limit trapped");
	over_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_PUSH && sp_q > limit_q) |=> stack_trap
		##1 (!stack_trap || $past(op != SLPAG_OP_NONE)))
		else $error("push past limit missed trap");
	floor_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == SLPAG_OP_REF && sp_q < 16'h0800) |=> stack_trap)
		else $error("underflow not trapped");
	table_form_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tbl_req && !tbl_write) |=>
		(prog_addr == {$past(tbl_page_q), $past(tbl_ea)}) && prog_valid)
		else $error("table address wrong");
	remap_form_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!tbl_req && remap_hit) |=> prog_valid && !prog_addr[23]
		&& prog_addr[15] == $past(vis_page_q[0]) && prog_low_word_only)
		else $error("remap address wrong");
	cfg_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tbl_req && tbl_write && tbl_page_q[7]) |=> prog_blocked && !prog_write)
		else $error("config write not blocked");
	remap_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!tbl_req && !(data_req && core_q[2] && data_ea[15])) |=> !prog_valid)
		else $error("remap without enable");
endmodule // slpag_core

// [slpag_cpu_model.sv]
`timescale 1ns/100ps
module slpag_cpu_model
	import slpag_pkg::*;
(
	// clock
	input wire logic pclk,
	// stack requests
	output logic [2:0] stack_op,
	output logic [23:0] pc_value,
	output logic [7:0] status_low_byte,
	// program space requests
	output logic tbl_req,
	output logic tbl_write,
	output logic [15:0] tbl_ea,
	output logic data_req,
	output logic [15:0] data_ea
);
	// idle datapath at time zero
	initial begin
		stack_op = SLPAG_OP_NONE;
		pc_value = 24'h000000;
		status_low_byte = 8'h00;
		tbl_req = 1'b0;
		tbl_write = 1'b0;
		tbl_ea = 16'h0000;
		data_req = 1'b0;
		data_ea = 16'h0000;
	end
	// one stack op per call; operands scrambled once dropped
	task automatic stk(input logic [2:0] op, input logic [23:0] pc,
		input logic [7:0] sr);
		@(posedge pclk);
		stack_op <= op;
		pc_value <= pc;
		status_low_byte <= sr;
		@(posedge pclk);
		stack_op <= SLPAG_OP_NONE;
		pc_value <= ~pc;
		status_low_byte <= ~sr;
	endtask
	// table request when t is set, else a data read for remap
	task automatic prg(input logic t, input logic w, input logic [15:0] ea);
		@(posedge pclk);
		tbl_req <= t;
		tbl_write <= w;
		tbl_ea <= ea;
		data_req <= !t;
		data_ea <= ea;
		@(posedge pclk);
		tbl_req <= 1'b0;
		data_req <= 1'b0;
		tbl_ea <= ~ea;
		data_ea <= ~ea;
	endtask
endmodule // slpag_cpu_model

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
	import slpag_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, r;
	logic pready, pslverr, e, stack_trap, prog_valid, prog_write, prog_config;
	logic prog_low_word_only, prog_blocked, tr, dq, tq, tw;
	logic [2:0] stack_op;
	logic [23:0] pc_value, prog_addr;
	logic [7:0] status_low_byte, pg;
	logic [15:0] stack_addr, te, de, sp, lim, ea;
	logic [31:0] stack_push_data;
	int err_total = 0, compares = 0, cyc = 0;
	// call and exception first so that the plain push lands on the limit
	logic [2:0] ops [4] = '{SLPAG_OP_CALL, SLPAG_OP_EXC, SLPAG_OP_PUSH,
		SLPAG_OP_REF};
	// 40 ns clock
	always #20 pclk = ~pclk;
	slpag_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stack_op(stack_op), .pc_value(pc_value),
		.status_low_byte(status_low_byte), .stack_addr(stack_addr),
		.stack_push_data(stack_push_data), .stack_trap(stack_trap),
		.tbl_req(tq), .tbl_write(tw), .tbl_ea(te), .data_req(dq),
		.data_ea(de), .prog_addr(prog_addr), .prog_valid(prog_valid),
		.prog_write(prog_write), .prog_config(prog_config),
		.prog_low_word_only(prog_low_word_only),
		.prog_blocked(prog_blocked));
	slpag_cpu_model cpu (.pclk(pclk), .stack_op(stack_op),
		.pc_value(pc_value), .status_low_byte(status_low_byte),
		.tbl_req(tq), .tbl_write(tw), .tbl_ea(te), .data_req(dq),
		.data_ea(de));
	task automatic end_of_test;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, far above the roughly 150 cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// apb master: held until pready seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready, tied high in the core, ends this wait at the first edge; the bench timeout guards a hang
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// the limit only guards pushes; the floor guards every stack address
	function automatic logic trap_exp(input logic [15:0] a, input logic p);
		return (p && a > lim) || a < SLPAG_STACK_FLOOR;
	endfunction
	// one stack op against a shadow pointer
	task automatic sop(input logic [2:0] op);
		logic [23:0] pc;
		logic [7:0] sr;
		logic [15:0] a;
		pc = 24'($urandom);
		sr = 8'($urandom);
		if (op == SLPAG_OP_POP) sp = sp - SLPAG_WORD_STEP;
		a = sp;
		if (op != SLPAG_OP_POP && op != SLPAG_OP_REF) sp = sp + 16'h0002;
		cpu.stk(op, pc, sr);
		#1;
		chk(stack_addr, a);
		chk(stack_trap, trap_exp(a, op != SLPAG_OP_POP
			&& op != SLPAG_OP_REF));
		if (op == SLPAG_OP_EXC) chk(stack_push_data, {sr, pc});
		if (op == SLPAG_OP_CALL) chk(stack_push_data, {8'h00, pc});
	endtask
	// main sequence
	initial begin
		void'($urandom(32'hB97833F1));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SLPAG_OFF_STACK_PTR, 0);
		chk(r, 32'h00000800);
		apb(1'b1, SLPAG_OFF_STACK_LIMIT, 32'h00000DF5);
		apb(1'b0, SLPAG_OFF_STACK_LIMIT, 0);
		chk(r, 32'h00000DF4);
		lim = 16'h0DF4;
		apb(1'b0, 12'h020, 0);
		chk(r, 32'h00000000);
		chk(e, 1'b1);
		apb(1'b1, SLPAG_OFF_STACK_PTR, 32'h00000DF0);
		sp = 16'h0DF0;
		$display("registers done");
		// limit write is followed by apb reads and a pointer write, not a stack read
		for (int i = 0; i < 3; i++) sop(ops[i]);
		sop(SLPAG_OP_PUSH);
		apb(1'b1, SLPAG_OFF_STACK_PTR, 32'h00000802);
		sp = 16'h0802;
		sop(SLPAG_OP_POP);
		sop(SLPAG_OP_POP);
		sop(SLPAG_OP_REF);
		apb(1'b1, SLPAG_OFF_STACK_PTR, 32'h00000900);
		sp = 16'h0900;
		for (int i = 0; i < 8; i++) sop(ops[$urandom % 4]);
		$display("stack done");
		for (int i = 0; i < 8; i++) begin
			// corners: config write, then odd config read, then random
			pg = (i < 2) ? 8'h80 : 8'($urandom);
			tr = (i == 0) | ((i > 1) & 1'($urandom));
			ea = 16'($urandom) | 16'(i == 1);
			apb(1'b1, SLPAG_OFF_TABLE_PAGE, {24'h0, pg});
			cpu.prg(1'b1, tr, ea);
			#1;
			chk(prog_blocked, pg[7] & tr);
			chk(prog_valid, !(pg[7] & tr));
			if (!(pg[7] & tr)) begin
				chk({prog_addr, prog_write}, {pg, ea, tr});
			end
			chk(prog_config, pg[7]);
		end
		$display("table done");
		for (int i = 0; i < 6; i++) begin
			pg = i[0] ? SLPAG_VIS_EEPROM : SLPAG_VIS_PROGRAM;
			ea = 16'($urandom) | ((i < 4) ? 16'h8000 : 16'h0000);
			ea[15] = (i < 4);
			apb(1'b1, SLPAG_OFF_CORE_CTRL, {29'h0, i[1] | (i > 3), 2'h0});
			apb(1'b1, SLPAG_OFF_VIS_PAGE, {24'h0, pg});
			cpu.prg(1'b0, 1'b0, ea);
			#1;
			chk(prog_valid, ea[15] & (i[1] | (i > 3)));
			if (ea[15] & (i[1] | (i > 3))) begin
				chk(prog_addr, {1'b0, pg, ea[14:0]});
				chk(prog_low_word_only, 1'b1);
			end
		end
		// a page other than the two meaningful ones is flagged
		apb(1'b1, SLPAG_OFF_VIS_PAGE, 32'h0000005A);
		apb(1'b0, SLPAG_OFF_STATUS, 0);
		chk(r, 32'h00000002);
		apb(1'b0, SLPAG_OFF_VIS_PAGE, 0);
		chk(r, 32'h0000005A);
		$display("remap done");
		end_of_test();
	end
endmodule // tb_top
